// [verilog/mrp_pkg.sv]
package mrp_pkg;
    // port widths
    localparam int MGMT_ADDR_W          = 16;
    localparam int WORD_W               = 32;
    localparam int CFG_OFFSET_W_NARROW  = 11;
    localparam int CFG_OFFSET_W_WIDE    = 20;
    localparam int CHANNEL_SELECT_WIDTH = 2;
    localparam int CMD_ADDR_W           = 32;

    // clock rate and allowed management clock band
    localparam int CLK_MHZ           = 50;
    localparam int MGMT_CLK_MIN_MHZ  = 100;
    localparam int MGMT_CLK_MAX_MHZ  = 125;

    // device timing
    localparam int MGMT_READ_LATENCY = 2;
    localparam int CFG_STALL_CYCLES  = 3;

    // host read timeout, time in ns and cycles derived (rounded down)
    localparam int MGMT_TIMEOUT_NS     = 1000;
    localparam int MGMT_TIMEOUT_CYCLES = MGMT_TIMEOUT_NS * CLK_MHZ / 1000;

    // management register space held by the device
    localparam int MGMT_REG_COUNT            = 16;
    localparam logic [15:0] MGMT_CTRL_OFFSET   = 16'h0000;
    localparam logic [15:0] MGMT_STATUS_OFFSET = 16'h0001;
    localparam logic [31:0] MGMT_RESET_VALUE   = 32'h0000_0000;

    // transceiver register words kept per channel
    localparam int PCS_WORDS_PER_CHANNEL = 16;

    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_MGMT = 2'b01,
        HS_CFG  = 2'b10,
        HS_DONE = 2'b11
    } mrp_host_state_type;

    typedef enum logic [1:0] {
        DS_IDLE = 2'b00,
        DS_BUSY = 2'b01,
        DS_DONE = 2'b10
    } mrp_cfg_state_type;
endpackage : mrp_pkg

// [verilog/mrp_if.sv]
`timescale 1ns/1ns
interface mrp_if
#(
    parameter int CH_W  = mrp_pkg::CHANNEL_SELECT_WIDTH,
    parameter int OFF_W = mrp_pkg::CFG_OFFSET_W_NARROW
)
(
    input wire logic clk,
    input wire logic rst_b
);
    import mrp_pkg::*;
    // management port
    logic                   mgmtRdStrobe;
    logic                   mgmtWrStrobe;
    logic [MGMT_ADDR_W-1:0] mgmtAddress;
    logic [WORD_W-1:0]      mgmtWriteWord;
    logic [WORD_W-1:0]      mgmtReadWord;
    logic                   mgmtReadWordQualifier;
    // transceiver reconfiguration port
    logic                   xcvrCfgReset;
    logic                   xcvrCfgRd;
    logic                   xcvrCfgWr;
    logic [CH_W+OFF_W-1:0]  xcvrCfgAddr;
    logic [WORD_W-1:0]      xcvrCfgWriteWord;
    logic [WORD_W-1:0]      xcvrCfgReadWord;
    logic                   xcvrCfgStall;

    modport device (
        input  clk, rst_b, mgmtRdStrobe, mgmtWrStrobe, mgmtAddress,
        input  mgmtWriteWord, xcvrCfgReset, xcvrCfgRd, xcvrCfgWr,
        input  xcvrCfgAddr, xcvrCfgWriteWord,
        output mgmtReadWord, mgmtReadWordQualifier,
        output xcvrCfgReadWord, xcvrCfgStall
    );
    modport host (
        input  clk, rst_b, mgmtReadWord, mgmtReadWordQualifier,
        input  xcvrCfgReadWord, xcvrCfgStall,
        output mgmtRdStrobe, mgmtWrStrobe, mgmtAddress, mgmtWriteWord,
        output xcvrCfgReset, xcvrCfgRd, xcvrCfgWr, xcvrCfgAddr,
        output xcvrCfgWriteWord
    );
endinterface : mrp_if

// [verilog/mrp_device.sv]
`timescale 1ns/1ns
module mrp_device
#(
    parameter int CH_W     = mrp_pkg::CHANNEL_SELECT_WIDTH,
    parameter int OFF_W    = mrp_pkg::CFG_OFFSET_W_NARROW,
    parameter int RD_LAT   = mrp_pkg::MGMT_READ_LATENCY,
    parameter int STALL_CY = mrp_pkg::CFG_STALL_CYCLES
)
(
    mrp_if.device                    bus,
    output logic [mrp_pkg::WORD_W-1:0] coreControl,
    input  wire logic [mrp_pkg::WORD_W-1:0] coreStatus
);
    import mrp_pkg::*;

    localparam int PCS_IDX_W = $clog2(PCS_WORDS_PER_CHANNEL);
    localparam int PCS_DEPTH = (2**CH_W) * PCS_WORDS_PER_CHANNEL;
    localparam int MGMT_IDX_W = $clog2(MGMT_REG_COUNT);

    // refuse shapes the logic cannot serve
    // the read pipe needs two stages, the stall counter holds 8 bits
    if (RD_LAT < 2 || STALL_CY < 1 || STALL_CY > 256 || CH_W < 1 ||
        !(OFF_W == CFG_OFFSET_W_NARROW || OFF_W == CFG_OFFSET_W_WIDE))
    begin : g_bad_param
        $error("mrp_device: unsupported parameter values");
    end

    logic [WORD_W-1:0]    mgmtRegs [MGMT_REG_COUNT];
    logic [RD_LAT-1:0]    rdValidPipe;
    logic [WORD_W-1:0]    rdDataPipe [RD_LAT];
    logic [WORD_W-1:0]    pcsRegs [PCS_DEPTH];
    mrp_cfg_state_type    cfgState;
    logic [7:0]           stallCount;

    // management decode
    wire                  mgmtInRange = bus.mgmtAddress < MGMT_REG_COUNT;
    wire [MGMT_IDX_W-1:0] mgmtIdx     = bus.mgmtAddress[MGMT_IDX_W-1:0];
    wire                  isStatus    = bus.mgmtAddress == MGMT_STATUS_OFFSET;
    wire [WORD_W-1:0]     mgmtLookup  = isStatus ? coreStatus
                                      : mgmtInRange ? mgmtRegs[mgmtIdx]
                                      : '0;
    // transceiver register decode: channel field above offset field
    wire [CH_W-1:0]       cfgChan  = bus.xcvrCfgAddr[CH_W+OFF_W-1:OFF_W];
    wire [PCS_IDX_W-1:0]  cfgWord  = bus.xcvrCfgAddr[PCS_IDX_W-1:0];
    wire [CH_W+PCS_IDX_W-1:0] pcsIdx = {cfgChan, cfgWord};
    wire                  cfgReq   = bus.xcvrCfgRd | bus.xcvrCfgWr;

    // management register writes
    // write strobe stores
    always_ff @(posedge bus.clk or negedge bus.rst_b)
    begin
        if (!bus.rst_b)
            for (int i = 0; i < MGMT_REG_COUNT; i++)
                mgmtRegs[i] <= MGMT_RESET_VALUE;
        else if (bus.mgmtWrStrobe && mgmtInRange && !isStatus)
            mgmtRegs[mgmtIdx] <= bus.mgmtWriteWord;
    end

    // read pipeline: data and its qualifier travel together
    // data qualified by valid
    always_ff @(posedge bus.clk or negedge bus.rst_b)
    begin
        if (!bus.rst_b)
        begin
            rdValidPipe <= '0;
            for (int i = 0; i < RD_LAT; i++)
                rdDataPipe[i] <= '0;
        end
        else
        begin
            rdValidPipe <= {rdValidPipe[RD_LAT-2:0], bus.mgmtRdStrobe};
            rdDataPipe[0] <= mgmtLookup;
            for (int i = 1; i < RD_LAT; i++)
                rdDataPipe[i] <= rdDataPipe[i-1];
        end
    end

    assign bus.mgmtReadWord          = rdDataPipe[RD_LAT-1];
    assign bus.mgmtReadWordQualifier = rdValidPipe[RD_LAT-1];
    assign coreControl               = mgmtRegs[0];

    // reconfiguration port: stall high, dropped for one accept cycle
    // synchronous high reset
    always_ff @(posedge bus.clk or negedge bus.rst_b)
    begin
        if (!bus.rst_b)
        begin
            cfgState            <= DS_IDLE;
            stallCount          <= '0;
            bus.xcvrCfgStall    <= 1'b1;
            bus.xcvrCfgReadWord <= '0;
        end
        else if (bus.xcvrCfgReset)
        begin
            cfgState            <= DS_IDLE;
            stallCount          <= '0;
            bus.xcvrCfgStall    <= 1'b1;
            bus.xcvrCfgReadWord <= '0;
        end
        else
        begin
            unique case (cfgState)
                DS_IDLE:
                begin
                    if (cfgReq)
                    begin
                        stallCount <= 8'(STALL_CY - 1);
                        cfgState   <= DS_BUSY;
                    end
                end
                DS_BUSY:
                begin
                    if (stallCount == 8'h00)
                    begin
                        bus.xcvrCfgStall    <= 1'b0;
                        bus.xcvrCfgReadWord <= pcsRegs[pcsIdx];
                        cfgState            <= DS_DONE;
                    end
                    else
                        stallCount <= stallCount - 8'h01;
                end
                DS_DONE:
                begin
                    bus.xcvrCfgStall <= 1'b1;
                    cfgState         <= DS_IDLE;
                end
                default:
                    cfgState <= DS_IDLE;
            endcase
        end
    end

    // transceiver register store, written in the accept cycle
    // channel plus offset
    always_ff @(posedge bus.clk or negedge bus.rst_b)
    begin
        if (!bus.rst_b)
            for (int i = 0; i < PCS_DEPTH; i++)
                pcsRegs[i] <= '0;
        else if (cfgState == DS_DONE && bus.xcvrCfgWr && !bus.xcvrCfgReset)
            pcsRegs[pcsIdx] <= bus.xcvrCfgWriteWord;
    end
endmodule : mrp_device

// [verilog/mrp_host.sv]
`timescale 1ns/1ns
// What this block does
// - management accesses timed by supplied clock
// - read strobe requests management read
// - write strobe requests management write
// - 16-bit address with every management access
// - read data counts only while qualified
// - write word valid with write strobe
// - reconfiguration reset high, synchronous
// - strobes start transceiver register accesses
// - address holds channel and register offset
// - write word valid with write strobe
// - stall high until read data ready
module mrp_host
#(
    parameter int CH_W    = mrp_pkg::CHANNEL_SELECT_WIDTH,
    parameter int OFF_W   = mrp_pkg::CFG_OFFSET_W_NARROW,
    parameter int TIMEOUT = mrp_pkg::MGMT_TIMEOUT_CYCLES
)
(
    mrp_if.host                              bus,
    input  wire logic                        cmdValid,
    output logic                             cmdReady,
    input  wire logic                        cmdToCfg,
    input  wire logic                        cmdWrite,
    input  wire logic [mrp_pkg::CMD_ADDR_W-1:0] cmdAddr,
    input  wire logic [mrp_pkg::WORD_W-1:0]  cmdWriteWord,
    input  wire logic                        cfgResetReq,
    output logic                             respValid,
    output logic [mrp_pkg::WORD_W-1:0]       respWord,
    output logic                             respTimeout
);
    import mrp_pkg::*;

    localparam int CFG_ADDR_W = CH_W + OFF_W;

    // refuse shapes the logic cannot serve
    if (TIMEOUT < 1 || TIMEOUT > 65535 || CFG_ADDR_W > CMD_ADDR_W ||
        !(OFF_W == CFG_OFFSET_W_NARROW || OFF_W == CFG_OFFSET_W_WIDE))
    begin : g_bad_param
        $error("mrp_host: unsupported parameter values");
    end

    mrp_host_state_type state;
    logic [15:0]        waitCount;
    logic               abortRead;

    // command decode
    wire takeCmd   = cmdValid && cmdReady;
    wire startMgmt = takeCmd && !cmdToCfg;
    wire startCfg  = takeCmd && cmdToCfg && !bus.xcvrCfgReset;
    wire abortCfg  = takeCmd && cmdToCfg && bus.xcvrCfgReset;
    wire cfgActive = bus.xcvrCfgRd || bus.xcvrCfgWr;
    wire cfgAccept = cfgActive && !bus.xcvrCfgStall;
    wire timedOut  = waitCount == 16'h0000;

    // reconfiguration reset follows the user request, one edge later
    // drive synchronous reset
    always_ff @(posedge bus.clk or negedge bus.rst_b)
    begin
        if (!bus.rst_b)
            bus.xcvrCfgReset <= 1'b1;
        else
            bus.xcvrCfgReset <= cfgResetReq;
    end

    // management strobes: one cycle each, address and data alongside
    // clocked by clk
    always_ff @(posedge bus.clk or negedge bus.rst_b)
    begin
        if (!bus.rst_b)
        begin
            bus.mgmtRdStrobe  <= 1'b0;
            bus.mgmtWrStrobe  <= 1'b0;
            bus.mgmtAddress   <= '0;
            bus.mgmtWriteWord <= '0;
        end
        else
        begin
            bus.mgmtRdStrobe <= startMgmt && !cmdWrite;
            bus.mgmtWrStrobe <= startMgmt && cmdWrite;
            if (startMgmt)
            begin
                bus.mgmtAddress   <= cmdAddr[MGMT_ADDR_W-1:0];
                bus.mgmtWriteWord <= cmdWriteWord;
            end
        end
    end

    // reconfiguration strobes held until the device stops stalling or the port reset rises
    // cfg strobes
    always_ff @(posedge bus.clk or negedge bus.rst_b)
    begin
        if (!bus.rst_b)
        begin
            bus.xcvrCfgRd        <= 1'b0;
            bus.xcvrCfgWr        <= 1'b0;
            bus.xcvrCfgAddr      <= '0;
            bus.xcvrCfgWriteWord <= '0;
        end
        else if (startCfg)
        begin
            bus.xcvrCfgRd        <= !cmdWrite;
            bus.xcvrCfgWr        <= cmdWrite;
            bus.xcvrCfgAddr      <= cmdAddr[CFG_ADDR_W-1:0];
            bus.xcvrCfgWriteWord <= cmdWriteWord;
        end
        else if (cfgAccept || bus.xcvrCfgReset)
        begin
            bus.xcvrCfgRd <= 1'b0;
            bus.xcvrCfgWr <= 1'b0;
        end
    end

    // sequencer: one outstanding command, answers on the response port
    always_ff @(posedge bus.clk or negedge bus.rst_b)
    begin
        if (!bus.rst_b)
        begin
            state       <= HS_IDLE;
            cmdReady    <= 1'b0;
            waitCount   <= '0;
            respValid   <= 1'b0;
            respWord    <= '0;
            respTimeout <= 1'b0;
            abortRead   <= 1'b0;
        end
        else
        begin
            respValid   <= 1'b0;
            respTimeout <= 1'b0;
            unique case (state)
                HS_IDLE:
                begin
                    cmdReady <= 1'b1;
                    if (takeCmd)
                    begin
                        cmdReady  <= 1'b0;
                        waitCount <= 16'(TIMEOUT);
                        // remember a read refused by the port reset
                        abortRead <= abortCfg && !cmdWrite;
                        if (abortCfg || (startMgmt && cmdWrite))
                            state <= HS_DONE;
                        else if (startMgmt)
                            state <= HS_MGMT;
                        else
                            state <= HS_CFG;
                    end
                end
                HS_MGMT:
                begin
                    if (bus.mgmtReadWordQualifier)
                    begin
                        respWord  <= bus.mgmtReadWord;
                        respValid <= 1'b1;
                        cmdReady  <= 1'b1;
                        state     <= HS_IDLE;
                    end
                    else if (timedOut)
                    begin
                        respTimeout <= 1'b1;
                        respValid   <= 1'b1;
                        cmdReady    <= 1'b1;
                        state       <= HS_IDLE;
                    end
                    else
                        waitCount <= waitCount - 16'h0001;
                end
                HS_CFG:
                begin
                    if (cfgAccept)
                    begin
                        if (bus.xcvrCfgRd)
                            respWord <= bus.xcvrCfgReadWord;
                        respValid <= 1'b1;
                        cmdReady  <= 1'b1;
                        state     <= HS_IDLE;
                    end
                    else if (bus.xcvrCfgReset)
                    begin
                        respTimeout <= 1'b1;
                        respValid   <= 1'b1;
                        cmdReady    <= 1'b1;
                        state       <= HS_IDLE;
                    end
                end
                HS_DONE:
                begin
                    respTimeout <= abortRead;
                    respValid   <= 1'b1;
                    cmdReady    <= 1'b1;
                    state       <= HS_IDLE;
                end
            endcase
        end
    end
endmodule : mrp_host

// [verif/mrp_checker.sv]
`timescale 1ns/1ns
module mrp_checker
#(
    parameter int CH_W  = mrp_pkg::CHANNEL_SELECT_WIDTH,
    parameter int OFF_W = mrp_pkg::CFG_OFFSET_W_NARROW
)
(
    input wire logic                  clk,
    input wire logic                  rst_b,
    input wire logic                  mgmtRdStrobe,
    input wire logic                  mgmtWrStrobe,
    input wire logic                  mgmtReadWordQualifier,
    input wire logic                  xcvrCfgReset,
    input wire logic                  xcvrCfgRd,
    input wire logic                  xcvrCfgWr,
    input wire logic [CH_W+OFF_W-1:0] xcvrCfgAddr,
    input wire logic [31:0]           xcvrCfgWriteWord,
    input wire logic [31:0]           xcvrCfgReadWord,
    input wire logic                  xcvrCfgStall
);
    import mrp_pkg::*;
    // one clock, the async reset silences every check
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // any request on each port
    wire cfgReq  = xcvrCfgRd || xcvrCfgWr;
    wire mgmtReq = mgmtRdStrobe || mgmtWrStrobe;

    a_qual_after_read: assert property (
        mgmtRdStrobe |-> ##2 mgmtReadWordQualifier)
        else $error("qualifier not two cycles after read");
    a_qual_has_read: assert property (
        mgmtReadWordQualifier |-> $past(mgmtRdStrobe, 2))
        else $error("qualifier without a read");
    a_mgmt_pulse: assert property (
        mgmtReq |=> !mgmtReq)
        else $error("management strobe longer than a cycle");
    // a port reset cuts an access short, so the span is not owed then
    a_stall_span: assert property (
        disable iff (!rst_b || xcvrCfgReset)
        $rose(cfgReq) |-> xcvrCfgStall[*4] ##1 !xcvrCfgStall)
        else $error("stall did not drop after four cycles");
    a_stall_cause: assert property (
        $fell(xcvrCfgStall) |-> $past(cfgReq, 4))
        else $error("stall dropped without a request");
    a_stall_short: assert property (
        !xcvrCfgStall |=> xcvrCfgStall)
        else $error("stall low longer than a cycle");
    a_req_held: assert property (
        cfgReq && xcvrCfgStall |=> xcvrCfgReset ||
        $stable({xcvrCfgRd, xcvrCfgWr, xcvrCfgAddr, xcvrCfgWriteWord}))
        else $error("request changed while stalled");
    a_req_dropped: assert property (
        cfgReq && !xcvrCfgStall |=> !cfgReq)
        else $error("request kept after acceptance");
    a_cfg_reset_idle: assert property (
        xcvrCfgReset |=> xcvrCfgStall && xcvrCfgReadWord == '0)
        else $error("reconfig side not idle in its reset");
endmodule : mrp_checker

// [verif/mgmt_and_xcvr_reconfig_port_tb.sv]
`timescale 1ns/1ns
module mgmt_and_xcvr_reconfig_port_tb;
    import mrp_pkg::*;
    typedef struct {
        logic        toCfg;
        logic        wr;
        logic [31:0] addr;
        logic [31:0] data;
        int          lat;
    } mrp_row_type;
    localparam int LIMIT = 3000;
    localparam logic [31:0] STATUS = 32'h1234_5678;
    localparam logic [31:0] MMASK = (32'h1 << MGMT_ADDR_W) - 1;
    localparam logic [31:0] CMASK =
        (32'h1 << (CHANNEL_SELECT_WIDTH + CFG_OFFSET_W_NARROW)) - 1;
    // data is the write word, or the read word expected back
    mrp_row_type rows [11] = '{
        '{1'b0, 1'b1, 32'h0000_0000, 32'hA5A5_0001, 2},
        '{1'b0, 1'b0, 32'h0000_0000, 32'hA5A5_0001, 4},
        '{1'b0, 1'b1, 32'h0000_0001, 32'hFFFF_FFFF, 2},
        '{1'b0, 1'b0, 32'h0000_0001, 32'h1234_5678, 4},
        '{1'b0, 1'b1, 32'h0000_0010, 32'h0BAD_0010, 2},
        '{1'b0, 1'b0, 32'h0000_0010, 32'h0000_0000, 4},
        '{1'b0, 1'b0, 32'h0001_0000, 32'hA5A5_0001, 4},
        '{1'b1, 1'b1, 32'h0000_1805, 32'hC0DE_0035, 6},
        '{1'b1, 1'b1, 32'h0000_0005, 32'h0000_0AB5, 6},
        '{1'b1, 1'b0, 32'h0000_1805, 32'hC0DE_0035, 6},
        '{1'b1, 1'b0, 32'h0000_0005, 32'h0000_0AB5, 6}
    };
    logic             clk;
    logic             rst_b;
    logic             cmdValid;
    logic             useTwo;
    logic             cmdToCfg;
    logic             cmdWrite;
    logic             cfgResetReq;
    logic [31:0]      cmdAddr;
    logic [31:0]      cmdWriteWord;
    logic [31:0]      coreControl;
    logic [31:0]      seenAddr;
    logic [31:0]      seenData;
    logic [1:0]       cmdReady;
    logic [1:0]       respValid;
    logic [1:0]       respTimeout;
    logic [1:0][31:0] respWord;
    int               errors;
    int               compares;
    int               cycles;
    int               strobes;
    int               mark;

    mrp_if bif (.clk(clk), .rst_b(rst_b));
    mrp_if dif (.clk(clk), .rst_b(rst_b));
    mrp_device mrp_device_i (.bus(bif.device), .coreControl(coreControl),
        .coreStatus(STATUS));
    mrp_host #(.TIMEOUT(8)) mrp_host_i (.bus(bif.host),
        .cmdValid(cmdValid && !useTwo), .cmdReady(cmdReady[0]),
        .cmdToCfg(cmdToCfg), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr),
        .cmdWriteWord(cmdWriteWord), .cfgResetReq(cfgResetReq),
        .respValid(respValid[0]), .respWord(respWord[0]),
        .respTimeout(respTimeout[0]));
    mrp_host #(.TIMEOUT(8)) mrp_host_dead_i (.bus(dif.host),
        .cmdValid(cmdValid && useTwo), .cmdReady(cmdReady[1]),
        .cmdToCfg(cmdToCfg), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr),
        .cmdWriteWord(cmdWriteWord), .cfgResetReq(cfgResetReq),
        .respValid(respValid[1]), .respWord(respWord[1]),
        .respTimeout(respTimeout[1]));
    mrp_checker #(.CH_W(CHANNEL_SELECT_WIDTH),
        .OFF_W(CFG_OFFSET_W_NARROW)) mrp_checker_i (.clk(clk),
        .rst_b(rst_b), .mgmtRdStrobe(bif.mgmtRdStrobe),
        .mgmtWrStrobe(bif.mgmtWrStrobe),
        .mgmtReadWordQualifier(bif.mgmtReadWordQualifier),
        .xcvrCfgReset(bif.xcvrCfgReset), .xcvrCfgRd(bif.xcvrCfgRd),
        .xcvrCfgWr(bif.xcvrCfgWr), .xcvrCfgAddr(bif.xcvrCfgAddr),
        .xcvrCfgWriteWord(bif.xcvrCfgWriteWord),
        .xcvrCfgReadWord(bif.xcvrCfgReadWord),
        .xcvrCfgStall(bif.xcvrCfgStall));

    // 50 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // dead far side: never qualifies, never accepts, words keep toggling
    initial
    begin
        dif.mgmtReadWordQualifier = 1'b0;
        dif.xcvrCfgStall = 1'b1;
        dif.mgmtReadWord = 32'h5A5A_5A5A;
        dif.xcvrCfgReadWord = 32'hA5A5_A5A5;
        forever
        begin
            @(negedge clk);
            dif.mgmtReadWord = ~dif.mgmtReadWord;
            dif.xcvrCfgReadWord = ~dif.xcvrCfgReadWord;
        end
    end
    // wire capture, strobe count and hang guard
    always @(posedge clk)
    begin
        if (bif.mgmtRdStrobe || bif.mgmtWrStrobe)
        begin
            seenAddr <= 32'(bif.mgmtAddress);
            seenData <= bif.mgmtWriteWord;
        end
        if (bif.xcvrCfgRd || bif.xcvrCfgWr)
        begin
            seenAddr <= 32'(bif.xcvrCfgAddr);
            seenData <= bif.xcvrCfgWriteWord;
            strobes <= strobes + 1;
        end
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            errors++;
            report_and_stop();
        end
    end

    task check32(input string what, input logic [31:0] exp,
                 input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check32

    task check1(input string what, input logic exp, input logic got);
        check32(what, {31'h0, exp}, {31'h0, got});
    endtask : check1

    // offer one command, wait for its answer, count the cycles
    task automatic run_cmd(input mrp_row_type r, input logic expTo);
        int n;
        cmdToCfg = r.toCfg;
        cmdWrite = r.wr;
        cmdAddr = r.addr;
        cmdWriteWord = r.data;
        cmdValid = 1'b1;
        n = 0;
        while (cmdReady[useTwo] !== 1'b1 && n < 20)
        begin
            @(negedge clk);
            n++;
        end
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
            if (n == 1)
                cmdValid = 1'b0;
        end
        while (respValid[useTwo] !== 1'b1 && n < 40);
        check32("answer cycles", 32'(r.lat), 32'(n));
        check1("answer timeout", expTo, respTimeout[useTwo]);
        if (!r.wr && !expTo)
            check32("read word", r.data, respWord[useTwo]);
    endtask : run_cmd

    task apply_reset;
        rst_b = 1'b0;
        repeat (5) @(negedge clk);
        check1("stall in reset", 1'b1, bif.xcvrCfgStall);
        check1("qualifier in reset", 1'b0,
            bif.mgmtReadWordQualifier);
        check1("ready in reset", 1'b0, cmdReady[0]);
        check32("control in reset", MGMT_RESET_VALUE, coreControl);
        rst_b = 1'b1;
        $display("reset test done");
    endtask : apply_reset

    task report_and_stop;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : report_and_stop

    // main sequence
    initial
    begin
        cmdValid = 1'b0;
        useTwo = 1'b0;
        cmdToCfg = 1'b0;
        cmdWrite = 1'b0;
        cmdAddr = 32'h0000_0000;
        cmdWriteWord = 32'h0000_0000;
        cfgResetReq = 1'b0;
        apply_reset();
        foreach (rows[i])
        begin
            run_cmd(rows[i], 1'b0);
            check32("bus address", rows[i].addr &
                (rows[i].toCfg ? CMASK : MMASK), seenAddr);
            if (rows[i].wr)
                check32("bus write word", rows[i].data,
                    seenData);
            $display("row %0d done", i);
        end
        check32("control word", 32'hA5A5_0001, coreControl);
        // command refused while the reconfig port is held in reset
        cfgResetReq = 1'b1;
        @(negedge clk);
        check1("reconfig reset", 1'b1, bif.xcvrCfgReset);
        mark = strobes;
        run_cmd(mrp_row_type'{1'b1, 1'b0, CMASK, 32'h0, 2}, 1'b1);
        check32("cfg strobes", 32'(mark), 32'(strobes));
        cfgResetReq = 1'b0;
        @(negedge clk);
        run_cmd(rows[7], 1'b0);
        run_cmd(rows[9], 1'b0);
        // port reset rises at the edge that takes a read: one strobe
        // cycle, then the access is cut and answered as timed out
        mark = strobes;
        cfgResetReq = 1'b1;
        run_cmd(mrp_row_type'{1'b1, 1'b0, 32'h5, 32'h0, 2}, 1'b1);
        check32("cut strobes", 32'(mark + 1), 32'(strobes));
        cfgResetReq = 1'b0;
        @(negedge clk);
        $display("reconfig reset test done");
        // far side that never qualifies its read word
        useTwo = 1'b1;
        run_cmd(mrp_row_type'{1'b0, 1'b0, 32'h3, 32'h0, 10}, 1'b1);
        check32("dead side address", 32'h3, 32'(dif.mgmtAddress));
        useTwo = 1'b0;
        $display("timeout test done");
        apply_reset();
        run_cmd(mrp_row_type'{1'b0, 1'b0, 32'h0,
                MGMT_RESET_VALUE, 4}, 1'b0);
        $display("reset read test done");
        report_and_stop();
    end
endmodule : mgmt_and_xcvr_reconfig_port_tb
